// ==== spibc_bench.sv ====
// spibc_bench: self-checking bench for spibc_top with a slave peer
// assumes spibc_peer and spibc_chk are compiled before it
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD t=%0t got %0h exp %0h", $time, (g), (e)); end end
module spibc_bench;
  import spibc_pkg::*;
  // ==================================================
  // stimulus rows: divider code and byte sent
  typedef struct packed {logic [1:0] div; logic [7:0] tx;} spibc_row_t;
  spibc_row_t rows [4] = '{'{2'h0, 8'hA5}, '{2'h1, 8'h5A}, '{2'h2, 8'h81}, '{2'h3, 8'h7E}};
  logic [7:0] ra [5] = '{ADDR_CFG1, ADDR_CFG2, ADDR_RX, ADDR_TX, 8'h00};
  logic [7:0] re [5] = '{8'h10, 8'h00, 8'h00, 8'h00, 8'h00};
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] sfrAddr = 8'h00;
  logic sfrWrite = 1'b0;
  logic sfrRead = 1'b0;
  spibc_byte_t sfrWdata = 8'h00;
  spibc_byte_t sfrRdata;
  logic spiIrq, sclkOut, sclkOe, mosiOut, mosiOe, misoOut, misoOe, ssOut, ssOe;
  logic sclkIn = 1'b0;
  logic mosiIn = 1'b0;
  logic ssIn = 1'b1;
  logic peerMiso;
  logic [7:0] peerGot, peerCnt;
  logic [7:0] base = 8'h40; // peer reply seed
  logic [7:0] sb = 8'hC3; // byte sent to the slave
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  int ssRises = 0;
  int hi = 0;
  int lastHi = 0;
  int sent = 0; // bytes the peer has answered
  // shared line: design drives miso only as a slave
  wire misoIn = misoOe ? misoOut : peerMiso;
  wire peerSs = ssOe ? ssOut : 1'b1; // pull-up when released
  spibc_top #(.DEPTH(2)) dut_u (.clk_sys, .rst_n, .sfrAddr, .sfrWrite, .sfrRead,
    .sfrWdata, .sfrRdata, .spiIrq, .sclkIn, .sclkOut, .sclkOe, .mosiIn, .mosiOut,
    .mosiOe, .misoIn, .misoOut, .misoOe, .ssIn, .ssOut, .ssOe);
  spibc_peer peer_u (.clk_sys, .sclk(sclkOut), .mosi(mosiOut), .ssN(peerSs), .base,
    .miso(peerMiso), .got(peerGot), .nb(peerCnt));
  always #20 clk_sys = ~clk_sys;
  always @(posedge ssOut) ssRises++;
  // ==================================================
  // high-phase length of the serial clock, and the hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (sclkOut) begin
      hi++;
    end else if (hi != 0) begin
      lastHi = hi;
      hi = 0;
    end
    if (cycles == 60000) begin
      num_errors++;
      wrap_up();
    end
  end
  // ==================================================
  // bus tasks: drive after an edge, hold through the taking edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    sfrAddr <= a;
    sfrWdata <= v;
    sfrWrite <= 1'b1;
    @(posedge clk_sys);
    sfrWrite <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    sfrAddr <= a;
    sfrRead <= 1'b1;
    @(posedge clk_sys);
    sfrRead <= 1'b0;
    @(negedge clk_sys);
    d = sfrRdata;
    @(posedge clk_sys);
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    `CHK(d, e)
  endtask
  // poll until tx drained and shifter idle (busy covers the gap), then wait 80 more cycles
  task automatic settle;
    logic [7:0] s;
    int k;
    k = 0;
    s = 8'h00;
    while (k < 900 && !(s[ST_TXEMPTY_BIT] && !s[ST_BUSY_BIT])) begin
      rd(ADDR_STAT, s);
      k++;
    end
    tick(80);
  endtask
  task automatic note(input string n);
    $display("done %s, bad so far %0d", n, num_errors);
  endtask
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ==================================================
  // main sequence
  initial begin
    logic [7:0] d;
    int e;
    logic [7:0] rb; // bits seen on the slave output
    tick(16);
    rst_n <= 1'b1;
    tick(1);
    `CHK({ssOut, sclkOe, mosiOe, misoOe, ssOe}, 5'h10)
    foreach (ra[i]) rdChk(ra[i], re[i]);
    wr(ADDR_CFG1, 8'h2D);
    rdChk(ADDR_CFG1, 8'h2D);
    note("reset");
    // one single-byte master transfer per divider code
    foreach (rows[i]) begin
      wr(ADDR_CFG1, {6'h04, rows[i].div});
      wr(ADDR_CFG2, 8'h50);
      // count select edges only after auto select has raised the pin
      e = ssRises;
      wr(ADDR_TX, rows[i].tx);
      settle();
      `CHK(peerGot, rows[i].tx)
      `CHK(lastHi, 4 << rows[i].div)
      `CHK(ssRises, e + 1)
      rdChk(ADDR_RX, base + sent[7:0]);
      sent++;
    end
    note("rows");
    // tx-empty interrupt follows the queue level
    e = ssRises;
    wr(ADDR_CFG1, 8'h30);
    // irq is registered behind the config, one edge later
    tick(1);
    `CHK(spiIrq, 1'b1)
    wr(ADDR_TX, 8'h11);
    wr(ADDR_TX, 8'h22);
    tick(3);
    `CHK(spiIrq, 1'b0)
    settle();
    `CHK(spiIrq, 1'b1)
    `CHK(ssRises, e + 2)
    rdChk(ADDR_RX, base + sent[7:0]);
    rdChk(ADDR_RX, base + 8'(sent + 1));
    sent += 2;
    note("irq");
    // four bytes into two entries plus hold: drop or replace
    for (int v = 0; v < 2; v++) begin
      wr(ADDR_CFG1, {5'h02, v[0], 2'h0});
      repeat (2) begin
        wr(ADDR_TX, 8'h33);
        wr(ADDR_TX, 8'h44);
        settle();
      end
      `CHK(spiIrq, 1'b1)
      rd(ADDR_STAT, d);
      `CHK(d[ST_RXOVF_BIT], 1'b1)
      rdChk(ADDR_RX, base + sent[7:0]);
      rdChk(ADDR_RX, base + 8'(sent + 1));
      rdChk(ADDR_RX, base + 8'(sent + 2 + v));
      tick(1);
      `CHK(spiIrq, 1'b0)
      wr(ADDR_STAT, 8'h10);
      sent += 4;
    end
    note("overflow");
    // disabled port queues but never shifts; third write refused
    wr(ADDR_CFG2, 8'h00);
    wr(ADDR_TX, 8'h01);
    wr(ADDR_TX, 8'h02);
    wr(ADDR_TX, 8'h03);
    tick(20);
    rd(ADDR_STAT, d);
    `CHK(d & 8'h2A, 8'h22)
    e = ssRises;
    wr(ADDR_CFG2, 8'hD0);
    settle();
    `CHK(ssRises, e + 1)
    `CHK(peerGot, 8'h02)
    rdChk(ADDR_RX, base + sent[7:0]);
    rdChk(ADDR_RX, base + 8'(sent + 1));
    wr(ADDR_CFG1, 8'h00);
    tick(2);
    `CHK(ssOut, 1'b0)
    note("continuous");
    // slave with the select pin as input
    wr(ADDR_CFG2, 8'h40);
    wr(ADDR_CFG1, 8'h08);
    // queued while deselected, fetched when select falls
    wr(ADDR_TX, 8'h96);
    ssIn <= 1'b0;
    tick(4);
    for (int i = 7; i >= 0; i--) begin
      mosiIn <= sb[i];
      tick(3);
      rb[i] = misoOut;
      sclkIn <= 1'b1;
      tick(3);
      sclkIn <= 1'b0;
      tick(1);
    end
    `CHK(rb, 8'h96)
    `CHK(misoOe, 1'b1)
    ssIn <= 1'b1;
    tick(4);
    `CHK(misoOe, 1'b0)
    rdChk(ADDR_RX, sb);
    note("slave");
    wrap_up();
  end
endmodule
`default_nettype wire

// ==== spibc_chk.sv ====
// spibc_chk: port-level assertions for spibc_top
// assumes one core clock and a synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module spibc_chk
  import spibc_pkg::*;
#(
  parameter int DEPTH = 2
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] sfrAddr,
  input wire logic sfrRead,
  input wire spibc_pkg::spibc_byte_t sfrRdata,
  input wire logic sclkOut,
  input wire logic sclkOe,
  input wire logic mosiOut,
  input wire logic mosiOe,
  input wire logic misoOe,
  input wire logic ssOut,
  input wire logic ssOe
);
  // ==================================================
  // single domain: clock and reset given once
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // ==================================================
  // register bus
  chk_rdata_quiet: assert property (!$past(sfrRead) |-> sfrRdata == 8'h00)
    else $error("read data not zero outside a read");
  chk_tx_reads_zero: assert property (
    sfrRead && (sfrAddr == ADDR_TX || sfrAddr == 8'h00) |=> sfrRdata == 8'h00)
    else $error("write-only or unmapped read not zero");
  // ==================================================
  // serial clock: half period 4 to 32 core cycles
  chk_sclk_high: assert property ($rose(sclkOut) |-> sclkOut [*4])
    else $error("serial clock high too short");
  chk_sclk_fall: assert property ($rose(sclkOut) |-> ##[4:32] $fell(sclkOut))
    else $error("serial clock high too long");
  chk_sclk_low: assert property ($fell(sclkOut) |-> !sclkOut [*4])
    else $error("serial clock low too short");
  // data holds at each rising edge and for the first four core cycles of the high phase
  chk_mosi_hold: assert property ($rose(sclkOut) |-> $stable(mosiOut) [*4])
    else $error("data out moved while clock high");
  // ==================================================
  // select framing
  chk_sel_low: assert property (ssOe && sclkOut |-> !ssOut)
    else $error("select high while clock high");
  chk_sel_gap: assert property (ssOe && $rose(ssOut) |-> !sclkOut [*4])
    else $error("clock too soon after select release");
  // ==================================================
  // pin drivers follow the mode
  chk_oe_master: assert property (!ssOe |-> !sclkOe && !mosiOe)
    else $error("master pins driven outside master mode");
  chk_oe_slave: assert property (misoOe |-> !ssOe && !sclkOe)
    else $error("slave out driven in master mode");
  // main scenarios
  cover property ($rose(sclkOut));
  cover property (ssOe && $rose(ssOut));
  cover property ($rose(misoOe));
endmodule

bind spibc_top spibc_chk #(.DEPTH(DEPTH)) chk_u (.clk_sys, .rst_n, .sfrAddr, .sfrRead,
  .sfrRdata, .sclkOut, .sclkOe, .mosiOut, .mosiOe, .misoOe, .ssOut, .ssOe);
`default_nettype wire

// ==== spibc_fifo.sv ====
// spibc_fifo: small byte buffer, valid/ready on both sides
// assumes DEPTH is a power of two so the pointers wrap freely
`timescale 1ns/1ps
`default_nettype none
module spibc_fifo #(
  parameter int DEPTH = 2
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  spibc_fifo_if.store port
);
  import spibc_pkg::*;
  localparam int PW = (DEPTH > 2) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  spibc_byte_t mem [DEPTH]; // entries, no reset needed
  logic [PW-1:0] wrPtr; // next slot to fill
  logic [PW-1:0] rdPtr; // oldest entry
  logic [CW-1:0] count; // entries held
  logic push;
  logic pop;
  // ==================================================
  // handshake; a pop frees room for a push in the same cycle
  assign port.full = (count == CW'(DEPTH));
  assign port.empty = (count == '0);
  assign port.inReady = !port.full || port.outReady;
  assign port.outValid = !port.empty;
  assign port.outData = mem[rdPtr];
  assign push = port.inValid && port.inReady;
  assign pop = port.outValid && port.outReady;
  // storage write
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wrPtr] <= port.inData;
    end
  end
  // pointers and count
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (pop) begin
        rdPtr <= rdPtr + 1'b1;
      end
      // both at once leaves the level alone
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== spibc_fifo_if.sv ====
// spibc_fifo_if: valid/ready bundle around one byte buffer
// assumes both sides sit on the same core clock
`timescale 1ns/1ps
`default_nettype none
interface spibc_fifo_if;
  import spibc_pkg::*;
  // ==================================================
  // fill side
  spibc_byte_t inData;
  logic inValid;
  logic inReady;
  // drain side
  spibc_byte_t outData;
  logic outValid;
  logic outReady;
  // level flags
  logic full;
  logic empty;
  modport store (input inData, inValid, outReady,
    output inReady, outData, outValid, full, empty);
  modport user (output inData, inValid, outReady,
    input inReady, outData, outValid, full, empty);
endinterface
`default_nettype wire

// ==== spibc_peer.sv ====
// spibc_peer: behavioural mode-0 slave on the far side of the port
// assumes select is active low and idles high when released
`timescale 1ns/1ps
`default_nettype none
module spibc_peer (
  input wire logic clk_sys,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic ssN,
  input wire logic [7:0] base,
  output logic miso,
  output logic [7:0] got,
  output logic [7:0] nb
);
  logic [2:0] pos = 3'h0; // bit being presented
  logic [7:0] rx = 8'h00; // incoming shifter
  logic idle = 1'b0; // wandering level when released
  logic [7:0] reply; // byte offered in this frame
  // ==================================================
  // bit position, cleared while deselected
  always @(negedge sclk or posedge ssN) begin
    if (ssN) begin
      pos <= 3'h0;
    end else begin
      pos <= pos + 3'h1;
      // byte ends at its last fall
      if (pos == 3'h7) begin
        nb <= nb + 8'h01;
      end
    end
  end
  // sample on rising clock, msb first
  always @(posedge sclk) begin
    rx <= {rx[6:0], mosi};
    if (!ssN && pos == 3'h7) begin
      got <= {rx[6:0], mosi};
    end
  end
  // released line must not hold a stale bit
  always @(posedge clk_sys) begin
    idle <= ~idle;
  end
  initial begin
    nb = 8'h00;
    got = 8'h00;
  end
  // reply of each byte is base plus its index, msb first
  assign reply = base + nb;
  assign miso = ssN ? idle : reply[3'h7 - pos];
endmodule
`default_nettype wire

// ==== spibc_pkg.sv ====
// spibc_pkg: constants and types of the serial buffer and mode block
// assumes an 8-bit special-function-register bus on the core clock
package spibc_pkg;
  // ==================================================
  // register offsets
  localparam logic [7:0] ADDR_TX = 8'h9A; // tx buffer, write only
  localparam logic [7:0] ADDR_RX = 8'h9B; // rx buffer, read only
  localparam logic [7:0] ADDR_CFG1 = 8'hE8; // first config
  localparam logic [7:0] ADDR_CFG2 = 8'hE9; // second config
  localparam logic [7:0] ADDR_STAT = 8'hEA; // status
  // ==================================================
  // reset values
  localparam logic [7:0] RST_CFG1 = 8'h10;
  localparam logic [7:0] RST_CFG2 = 8'h00;
  localparam logic [7:0] RST_BUF = 8'h00;
  // ==================================================
  // first config fields
  localparam int IRQ_SRC_BIT = 5; // irq_source_select
  localparam int AUTO_SS_BIT = 4; // automatic select drive
  localparam int SS_EN_BIT = 3; // select input enable
  localparam int OVW_BIT = 2; // rx_overflow_overwrite
  localparam int DIV_LSB = 0; // master_clock_divider [1:0]
  // second config fields
  localparam int CONT_BIT = 7; // continuous_transfer_enable
  localparam int IF_EN_BIT = 6; // serial_if_enable
  localparam int MASTER_BIT = 4; // master_select
  // status fields
  localparam int ST_RXAV_BIT = 0;
  localparam int ST_TXFULL_BIT = 1;
  localparam int ST_TXEMPTY_BIT = 2;
  localparam int ST_BUSY_BIT = 3;
  localparam int ST_RXOVF_BIT = 4;
  localparam int ST_TXOVF_BIT = 5;
  // ==================================================
  // timing: divider code 0 gives core/8, i.e. half period of 4
  localparam int DIV_MIN = 8;
  localparam logic [5:0] HALF_BASE = 6'(DIV_MIN / 2);
  localparam int DATA_W = 8;
  localparam logic [2:0] LAST_BIT = 3'h7;
  // ==================================================
  // shifter states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SHIFT = 3'b010,
    ST_GAP = 3'b100
  } spibc_state_t;
  typedef logic [DATA_W-1:0] spibc_byte_t;
endpackage

// ==== spibc_top.sv ====
// spibc_top: serial port buffers, first config, master/slave shifter
// assumes a single-cycle register bus and pins synchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none
module spibc_top #(
  parameter int DEPTH = 2
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrite,
  input wire logic sfrRead,
  input wire spibc_pkg::spibc_byte_t sfrWdata,
  output spibc_pkg::spibc_byte_t sfrRdata,
  output logic spiIrq,
  input wire logic sclkIn,
  output logic sclkOut,
  output logic sclkOe,
  input wire logic mosiIn,
  output logic mosiOut,
  output logic mosiOe,
  input wire logic misoIn,
  output logic misoOut,
  output logic misoOe,
  input wire logic ssIn,
  output logic ssOut,
  output logic ssOe
);
  import spibc_pkg::*;
  // ==================================================
  // configuration and status
  spibc_byte_t cfgFirst; // serial_config_first
  spibc_byte_t cfgSecond; // serial_config_second
  spibc_byte_t rxBuffer; // serial_rx_buffer
  logic rxOverflow; // sticky, write 1 clears
  logic txOverflow; // sticky, write 1 clears
  logic ifEnable;
  logic isMaster;
  logic contMode;
  logic autoSs;
  logic ssEnable;
  logic overwrite;
  logic [5:0] halfPeriod; // core cycles per sclk half
  // ==================================================
  // shifter state
  spibc_state_t state;
  spibc_byte_t shiftTx; // outgoing byte
  spibc_byte_t shiftRx; // incoming byte
  logic [2:0] bitCnt; // bits done in this byte
  logic [5:0] halfCnt; // cycles into the half period
  logic sclkPrev; // slave edge detect
  logic slaveLoaded; // slave byte fetched
  logic rxDone; // one-cycle byte complete
  spibc_byte_t rxByte; // byte that just completed
  logic rxPend; // byte waiting for the rx fifo
  spibc_byte_t rxHold;
  // ==================================================
  // decoded strobes
  logic halfTick;
  logic lastFall;
  logic slaveSel;
  logic sRise;
  logic sFall;
  logic slaveLoad;
  logic txTake;
  logic txWrite;
  logic rxRead;
  spibc_fifo_if txQ ();
  spibc_fifo_if rxQ ();
  assign ifEnable = cfgSecond[IF_EN_BIT];
  assign isMaster = cfgSecond[MASTER_BIT];
  assign contMode = cfgSecond[CONT_BIT];
  assign autoSs = cfgFirst[AUTO_SS_BIT];
  assign ssEnable = cfgFirst[SS_EN_BIT];
  assign overwrite = cfgFirst[OVW_BIT];
  assign halfPeriod = HALF_BASE << cfgFirst[DIV_LSB +: 2];
  assign txWrite = sfrWrite && (sfrAddr == ADDR_TX);
  assign rxRead = sfrRead && (sfrAddr == ADDR_RX);
  // ==================================================
  // buffers; the tx side stalls the shifter, never the writer
  // write goes to fifo input
  assign txQ.inData = sfrWdata;
  assign txQ.inValid = txWrite;
  assign txQ.outReady = txTake;
  assign rxQ.inData = rxHold;
  assign rxQ.inValid = rxPend;
  assign rxQ.outReady = rxRead;
  spibc_fifo #(.DEPTH(DEPTH)) txFifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .port(txQ)
  );
  spibc_fifo #(.DEPTH(DEPTH)) rxFifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .port(rxQ)
  );
  // ==================================================
  // edge and fetch decode
  assign halfTick = (halfCnt == halfPeriod - 6'd1);
  assign lastFall = halfTick && sclkOut && (bitCnt == LAST_BIT);
  // select input only counts when enabled
  assign slaveSel = ssEnable ? !ssIn : 1'b1;
  assign sRise = sclkIn && !sclkPrev && slaveSel;
  assign sFall = !sclkIn && sclkPrev && slaveSel;
  assign slaveLoad = slaveSel && !slaveLoaded;
  // when the shifter takes the tx fifo head
  always_comb begin
    txTake = 1'b0;
    if (ifEnable && txQ.outValid) begin
      if (isMaster) begin
        txTake = (state == ST_IDLE);
        if (state == ST_SHIFT && lastFall && contMode) begin
          txTake = 1'b1;
        end
      end else begin
        txTake = slaveLoad;
      end
    end
  end
  // ==================================================
  // shifter: master clocking, slave sampling, mode 0 timing
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      shiftTx <= RST_BUF;
      shiftRx <= RST_BUF;
      bitCnt <= '0;
      halfCnt <= '0;
      sclkOut <= 1'b0;
      sclkPrev <= 1'b0;
      slaveLoaded <= 1'b0;
      rxDone <= 1'b0;
      rxByte <= RST_BUF;
      misoOut <= 1'b0;
    end else begin
      rxDone <= 1'b0;
      sclkPrev <= sclkIn;
      if (!ifEnable) begin
        state <= ST_IDLE;
        sclkOut <= 1'b0;
        bitCnt <= '0;
        halfCnt <= '0;
        slaveLoaded <= 1'b0;
      end else if (isMaster) begin
        slaveLoaded <= 1'b0;
        unique case (state)
          ST_IDLE: begin
            halfCnt <= '0;
            sclkOut <= 1'b0;
            if (txTake) begin
              shiftTx <= txQ.outData;
              bitCnt <= '0;
              state <= ST_SHIFT;
            end
          end
          ST_SHIFT: begin
            halfCnt <= halfTick ? '0 : halfCnt + 6'd1;
            if (halfTick && !sclkOut) begin
              // rising edge samples the input
              sclkOut <= 1'b1;
              shiftRx <= {shiftRx[6:0], misoIn};
            end else if (halfTick) begin
              sclkOut <= 1'b0;
              shiftTx <= {shiftTx[6:0], 1'b0};
              bitCnt <= bitCnt + 3'd1;
              if (bitCnt == LAST_BIT) begin
                rxDone <= 1'b1;
                rxByte <= shiftRx;
                if (txTake) begin
                  shiftTx <= txQ.outData;
                end else begin
                  state <= ST_GAP;
                end
              end
            end
          end
          ST_GAP: begin
            // one half period with select released
            halfCnt <= halfTick ? '0 : halfCnt + 6'd1;
            if (halfTick) begin
              state <= ST_IDLE;
            end
          end
        endcase
      end else begin
        // slave: peer clocks, we follow its edges
        state <= ST_IDLE;
        halfCnt <= '0;
        sclkOut <= 1'b0;
        if (!slaveSel) begin
          bitCnt <= '0;
          slaveLoaded <= 1'b0;
        end else begin
          if (slaveLoad) begin
            // empty fifo sends zeros
            shiftTx <= txQ.outValid ? txQ.outData : RST_BUF;
            misoOut <= txQ.outValid && txQ.outData[7];
            slaveLoaded <= 1'b1;
          end
          if (sRise) begin
            shiftRx <= {shiftRx[6:0], mosiIn};
            bitCnt <= bitCnt + 3'd1;
            if (bitCnt == LAST_BIT) begin
              rxDone <= 1'b1;
              rxByte <= {shiftRx[6:0], mosiIn};
            end
          end
          if (sFall && slaveLoaded) begin
            shiftTx <= {shiftTx[6:0], 1'b0};
            misoOut <= shiftTx[6];
            // refetch after the full byte
            if (bitCnt == 3'd0) begin
              slaveLoaded <= 1'b0;
            end
          end
        end
      end
    end
  end
  // ==================================================
  // rx handoff; a blocked byte is the unread one
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rxPend <= 1'b0;
      rxHold <= RST_BUF;
    end else begin
      if (rxPend && rxQ.inReady) begin
        rxPend <= 1'b0;
      end
      if (rxDone) begin
        if (!rxPend || rxQ.inReady) begin
          rxPend <= 1'b1;
          rxHold <= rxByte;
        end else if (overwrite) begin
          rxHold <= rxByte;
        end
        // otherwise the new byte is lost
      end
    end
  end
  // ==================================================
  // pins; outputs registered, enables follow the mode
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mosiOut <= 1'b0;
      ssOut <= 1'b1;
      sclkOe <= 1'b0;
      mosiOe <= 1'b0;
      misoOe <= 1'b0;
      ssOe <= 1'b0;
    end else begin
      mosiOut <= shiftTx[7];
      sclkOe <= ifEnable && isMaster;
      mosiOe <= ifEnable && isMaster;
      ssOe <= ifEnable && isMaster;
      misoOe <= ifEnable && !isMaster && slaveSel;
      if (!autoSs) begin
        ssOut <= 1'b0;
      end else begin
        ssOut <= (state != ST_SHIFT);
      end
    end
  end
  // ==================================================
  // register writes; set of a sticky flag beats its clear
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cfgFirst <= RST_CFG1;
      cfgSecond <= RST_CFG2;
      rxOverflow <= 1'b0;
      txOverflow <= 1'b0;
    end else begin
      if (sfrWrite && sfrAddr == ADDR_CFG1) begin
        cfgFirst <= sfrWdata;
      end
      if (sfrWrite && sfrAddr == ADDR_CFG2) begin
        cfgSecond <= sfrWdata;
      end
      if (sfrWrite && sfrAddr == ADDR_STAT) begin
        if (sfrWdata[ST_RXOVF_BIT]) begin
          rxOverflow <= 1'b0;
        end
        if (sfrWdata[ST_TXOVF_BIT]) begin
          txOverflow <= 1'b0;
        end
      end
      if (rxDone && rxPend && !rxQ.inReady) begin
        rxOverflow <= 1'b1;
      end
      if (txWrite && !txQ.inReady) begin
        txOverflow <= 1'b1;
      end
    end
  end
  // ==================================================
  // register reads, answered one cycle later
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sfrRdata <= RST_BUF;
      rxBuffer <= RST_BUF;
    end else begin
      sfrRdata <= RST_BUF;
      if (sfrRead) begin
        unique case (sfrAddr)
          ADDR_RX: begin
            // head lands in the buffer register
            if (rxQ.outValid) begin
              rxBuffer <= rxQ.outData;
              sfrRdata <= rxQ.outData;
            end else begin
              sfrRdata <= rxBuffer;
            end
          end
          ADDR_CFG1: sfrRdata <= cfgFirst;
          ADDR_CFG2: sfrRdata <= cfgSecond;
          ADDR_STAT: begin
            sfrRdata[ST_RXAV_BIT] <= rxQ.outValid;
            sfrRdata[ST_TXFULL_BIT] <= txQ.full;
            sfrRdata[ST_TXEMPTY_BIT] <= txQ.empty;
            sfrRdata[ST_BUSY_BIT] <= (state != ST_IDLE);
            sfrRdata[ST_RXOVF_BIT] <= rxOverflow;
            sfrRdata[ST_TXOVF_BIT] <= txOverflow;
          end
          // tx buffer and unmapped read as zero
          default: sfrRdata <= RST_BUF;
        endcase
      end
    end
  end
  // ==================================================
  // interrupt: a level, not a latched event
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      spiIrq <= 1'b0;
    end else begin
      // drops when the read or write clears it
      if (cfgFirst[IRQ_SRC_BIT]) begin
        spiIrq <= ifEnable && txQ.empty;
      end else begin
        spiIrq <= ifEnable && rxQ.outValid;
      end
    end
  end
endmodule
`default_nettype wire
